/* File: inc/loopback_ctrl_defs.vh */
// Constants shared by the dataport loopback controller and its byte run counter.
`ifndef LOOPBACK_CTRL_DEFS_VH
`define LOOPBACK_CTRL_DEFS_VH

// Register byte offsets on the bus.
`define REG_CTRL 6'h00
`define REG_STATUS 6'h04
`define REG_SLOTS 6'h08
`define REG_SWITCH 6'h0C
`define CTRL_RESET 8'h00

// Option bit positions, shared by switches, control register and overhead byte.
`define OPT_LINE_CODE 0
`define OPT_FRAMING 1
`define OPT_SLOT_PATTERN 2
`define OPT_LATCHING 3
`define OPT_TIMEOUT 4
`define OPT_BANK_TYPE 5
`define OPT_PROTECTED 6
`define CTRL_USE_CRAFT 7

// In-band byte patterns, top bit ignored.
`define PAT_CLEAR 7'h3A
`define PAT_SEL_DP 7'h55
`define PAT_SEL_SVC 7'h31
`define PAT_SEL_NI 7'h41
`define PAT_PREP 7'h56
`define PAT_ACT 7'h5A

// Least byte counts of each stage.
`define CLEAR_MIN 35
`define SEL_MIN 35
`define PREP_MIN 100
`define MAP_AFTER 30
`define ACT_MIN 35

// Loopback targets.
`define TGT_NONE 2'h0
`define TGT_DP 2'h1
`define TGT_SVC 2'h2
`define TGT_NI 2'h3

// Channel limits and bank size.
`define CH_MIN 4'h2
`define CH_MAX 4'hC
`define BANK_SLOTS 24

// Loopback timeout in minutes and its cycle count at the core clock rate.
`define CLK_HZ 64'd250000000
`define LOOP_TIMEOUT_MIN 64'd20
`define LOOP_TIMEOUT_CYC (`LOOP_TIMEOUT_MIN * 64'd60 * `CLK_HZ)

`endif

/* File: rtl/byte_run_counter.v */
// Counter of consecutive received bytes matching one seven-bit pattern.
`timescale 1ns/1ps
`include "loopback_ctrl_defs.vh"

module byte_run_counter #(
	parameter [6:0] PATTERN = 7'h00,
	parameter [7:0] THRESH = 8'd35,
	parameter [7:0] MARK = 8'd35
) (
	input wire clk,
	input wire srst,
	input wire ce,
	input wire [7:0] byte_in,
	input wire valid_in,
	output reg hit_out,
	output reg mark_out
);

	reg [7:0] cnt_q;
	reg [7:0] cnt_d;

	// The run saturates at the threshold; any other byte drops it to zero.
	always @* begin
		cnt_d = cnt_q;
		if (valid_in) begin
			if (byte_in[6:0] == PATTERN) begin
				if (cnt_q != THRESH)
					cnt_d = cnt_q + 8'h01;
			end else begin
				cnt_d = 8'h00; // [RULE_22]
			end
		end
	end

	// Flags are registered so the caller sees them a cycle after the byte.
	always @(posedge clk) begin
		if (srst) begin
			cnt_q <= 8'h00;
			hit_out <= 1'b0;
			mark_out <= 1'b0;
		end else if (ce) begin
			cnt_q <= cnt_d;
			hit_out <= (cnt_d >= THRESH);
			mark_out <= (cnt_d >= MARK);
		end
	end

endmodule

/* File: rtl/fractional_dataport_loopback_ctrl.v */
// Fractional dataport provisioning, slot allocation and latching loopback control.
// Overview of operation
// RULE_01 - Carry 2 to 12 DS0s, rotary selected.
// RULE_02 - Send maintenance overhead bytes on the loop.
// RULE_03 - Channel count change keeps other provisioning.
// RULE_04 - Slots contiguous when switch on, else alternating.
// RULE_05 - No slot wrap past bank end.
// RULE_06 - 2B1Q loop code, DS1 toward bank.
// RULE_07 - Protected mode needs full four-stage sequence.
// RULE_08 - 35 clear bytes drop loopback, restart.
// RULE_09 - 35 select bytes name the target.
// RULE_10 - 100 prepare bytes follow valid select.
// RULE_11 - After 30 prepare bytes return map code.
// RULE_12 - 35 activate bytes latch the loopback.
// RULE_13 - Sender sends stages in order, minimum counts.
// RULE_14 - Latching loopback only when switch on.
// RULE_15 - Optional 20 minute automatic loopback release.
// RULE_16 - B8ZS when switch on, else AMI.
// RULE_17 - SF when switch off, ESF when on.
// RULE_18 - Smart two-state or dumb four-state signalling.
// RULE_19 - Craft registers can set every option.
// RULE_20 - Send options to remote unit after sync.
// RULE_21 - Flag hardware versus software provisioning mismatch.
// RULE_22 - Stage counter zeroes on non-matching byte.
// RULE_23 - Unprotected mode skips the clearing stage.
//
// Chosen here: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`include "loopback_ctrl_defs.vh"

module fractional_dataport_loopback_ctrl #(
	parameter [63:0] TIMEOUT_CYC = `LOOP_TIMEOUT_CYC,
	parameter [7:0] MAP_CODE = 8'h00
) (
	// Clock, reset and clock enable.
	input wire CORE_CLK_IN,
	input wire SRST_IN,
	input wire CE_IN,
	// AHB-Lite register slave.
	input wire HSEL_IN,
	input wire [31:0] HADDR_IN,
	input wire [1:0] HTRANS_IN,
	input wire HWRITE_IN,
	input wire [2:0] HSIZE_IN,
	input wire [31:0] HWDATA_IN,
	input wire HREADY_IN,
	output reg [31:0] HRDATA_OUT,
	output reg HREADYOUT_OUT,
	output reg HRESP_OUT,
	// Faceplate switches, rotary selector, card slot and loop sync pins.
	input wire LINE_CODE_SWITCH_IN,
	input wire FRAMING_SWITCH_IN,
	input wire SLOT_PATTERN_SWITCH_IN,
	input wire LATCHING_LOOP_SWITCH_IN,
	input wire LOOP_TIMEOUT_SWITCH_IN,
	input wire BANK_TYPE_SWITCH_IN,
	input wire PROTECTED_LOOP_SWITCH_IN,
	input wire [3:0] ROTARY_IN,
	input wire [4:0] CARD_SLOT_IN,
	input wire LOOP_SYNC_IN,
	// Received DS0 byte stream from the bank side.
	input wire [7:0] RX_BYTE_IN,
	input wire RX_BYTE_VALID_IN,
	// Overhead channel slot strobe from the loop transceiver.
	input wire OVH_SLOT_IN,
	// DS1 side and loop side provisioning.
	output reg B8ZS_OUT,
	output reg ESF_OUT,
	output reg FOUR_STATE_SIG_OUT,
	output reg LINE_2B1Q_OUT,
	output reg [23:0] SLOT_MASK_OUT,
	output reg [10:0] RATE_KBPS_OUT,
	// Loopback state and map code return.
	output reg LOOPBACK_OUT,
	output reg MAP_SEND_OUT,
	output reg [7:0] MAP_BYTE_OUT,
	// Overhead channel toward the remote unit.
	output reg [7:0] OVH_DATA_OUT,
	output reg OVH_VALID_OUT,
	// Provisioning mismatch indicator.
	output reg MISMATCH_OUT
);

	localparam [2:0] ST_HUNT_CLEAR = 3'h0;
	localparam [2:0] ST_HUNT_SEL = 3'h1;
	localparam [2:0] ST_PREP = 3'h2;
	localparam [2:0] ST_ACT = 3'h3;
	localparam [2:0] ST_LOOPED = 3'h4;

	wire [16:0] pins_raw;
	reg [16:0] sync1_q;
	reg [16:0] sync2_q;
	reg [16:0] sync3_q;
	reg [16:0] pins_q;
	wire [6:0] sw_opts;
	wire [3:0] rotary;
	wire [4:0] card_slot;
	wire loop_sync;
	reg [7:0] ctrl_q;
	wire [6:0] eff;
	reg [6:0] eff_prev_q;
	reg sync_prev_q;
	reg ovh_pend_q;
	reg [2:0] state_q;
	reg [1:0] target_q;
	reg [39:0] timer_q;
	reg [3:0] chan_n;
	reg [23:0] mask_d;
	reg [4:0] used_d;
	reg [31:0] diff;
	integer i;
	reg wr_pend_q;
	reg [5:0] wr_addr_q;
	reg [31:0] rd_mux;
	wire addr_ok;
	wire hit_clear;
	wire hit_dp;
	wire hit_svc;
	wire hit_ni;
	wire hit_prep;
	wire mark_prep;
	wire hit_act;
	wire m_sel_cur;
	wire m_prep;
	wire m_act;
	wire [2:0] start_state;
	wire timeout_hit;
	wire ovh_set;

	// Every pin is asynchronous to the core clock and goes through three flops.
	assign pins_raw = {LOOP_SYNC_IN, CARD_SLOT_IN, ROTARY_IN, PROTECTED_LOOP_SWITCH_IN,
		BANK_TYPE_SWITCH_IN, LOOP_TIMEOUT_SWITCH_IN, LATCHING_LOOP_SWITCH_IN,
		SLOT_PATTERN_SWITCH_IN, FRAMING_SWITCH_IN, LINE_CODE_SWITCH_IN};

	// A bit only changes once the second and third stages agree, filtering a bounce.
	always @(posedge CORE_CLK_IN) begin
		if (SRST_IN) begin
			sync1_q <= 17'h00000;
			sync2_q <= 17'h00000;
			sync3_q <= 17'h00000;
			pins_q <= 17'h00000;
		end else if (CE_IN) begin
			sync1_q <= pins_raw;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			pins_q <= (sync2_q & ~(sync2_q ^ sync3_q)) | (pins_q & (sync2_q ^ sync3_q));
		end
	end

	assign sw_opts = pins_q[6:0];
	assign rotary = pins_q[10:7];
	assign card_slot = pins_q[15:11];
	assign loop_sync = pins_q[16];

	// Craft settings replace the switch pack when software takes over.
	assign eff = ctrl_q[`CTRL_USE_CRAFT] ? ctrl_q[6:0] : sw_opts; // [RULE_19]

	// The rotary value is clamped to the supported channel range.
	always @* begin
		if (rotary < `CH_MIN)
			chan_n = `CH_MIN;
		else if (rotary > `CH_MAX)
			chan_n = `CH_MAX;
		else
			chan_n = rotary; // [RULE_01]
	end

	// Slot mask from the card position upward; slots past the bank end are dropped.
	always @* begin
		mask_d = 24'h000000;
		used_d = 5'h00;
		diff = 32'h00000000;
		for (i = 0; i < `BANK_SLOTS; i = i + 1) begin
			diff = i - card_slot;
			if (i >= card_slot) begin // [RULE_05]
				if (eff[`OPT_SLOT_PATTERN])
					mask_d[i] = (diff < chan_n); // [RULE_04]
				else
					mask_d[i] = (diff[0] == 1'b0) && (diff[31:1] < chan_n); // [RULE_04]
			end
			used_d = used_d + {4'h0, mask_d[i]};
		end
	end

	// Line and signalling provisioning follow the effective options; the loop code is fixed and the mismatch flag uses the synchronised switches.
	always @(posedge CORE_CLK_IN) begin
		if (SRST_IN) begin
			B8ZS_OUT <= 1'b0;
			ESF_OUT <= 1'b0;
			FOUR_STATE_SIG_OUT <= 1'b0;
			LINE_2B1Q_OUT <= 1'b0;
			SLOT_MASK_OUT <= 24'h000000;
			RATE_KBPS_OUT <= 11'h000;
			MISMATCH_OUT <= 1'b0;
		end else if (CE_IN) begin
			B8ZS_OUT <= eff[`OPT_LINE_CODE]; // [RULE_16]
			ESF_OUT <= eff[`OPT_FRAMING]; // [RULE_17]
			FOUR_STATE_SIG_OUT <= eff[`OPT_BANK_TYPE]; // [RULE_18]
			LINE_2B1Q_OUT <= 1'b1; // [RULE_06]
			SLOT_MASK_OUT <= mask_d; // [RULE_03]
			RATE_KBPS_OUT <= {used_d, 6'h00}; // [RULE_01]
			MISMATCH_OUT <= (sw_opts != ctrl_q[6:0]); // [RULE_21]
		end
	end

	// Stage counters, one per pattern, all watching the same byte stream.
	byte_run_counter #(.PATTERN(`PAT_CLEAR), .THRESH(`CLEAR_MIN), .MARK(`CLEAR_MIN)) u_clear (
		.clk(CORE_CLK_IN), .srst(SRST_IN), .ce(CE_IN), .byte_in(RX_BYTE_IN),
		.valid_in(RX_BYTE_VALID_IN), .hit_out(hit_clear), .mark_out());
	byte_run_counter #(.PATTERN(`PAT_SEL_DP), .THRESH(`SEL_MIN), .MARK(`SEL_MIN)) u_sel_dp (
		.clk(CORE_CLK_IN), .srst(SRST_IN), .ce(CE_IN), .byte_in(RX_BYTE_IN),
		.valid_in(RX_BYTE_VALID_IN), .hit_out(hit_dp), .mark_out());
	byte_run_counter #(.PATTERN(`PAT_SEL_SVC), .THRESH(`SEL_MIN), .MARK(`SEL_MIN)) u_sel_svc (
		.clk(CORE_CLK_IN), .srst(SRST_IN), .ce(CE_IN), .byte_in(RX_BYTE_IN),
		.valid_in(RX_BYTE_VALID_IN), .hit_out(hit_svc), .mark_out());
	byte_run_counter #(.PATTERN(`PAT_SEL_NI), .THRESH(`SEL_MIN), .MARK(`SEL_MIN)) u_sel_ni (
		.clk(CORE_CLK_IN), .srst(SRST_IN), .ce(CE_IN), .byte_in(RX_BYTE_IN),
		.valid_in(RX_BYTE_VALID_IN), .hit_out(hit_ni), .mark_out());
	byte_run_counter #(.PATTERN(`PAT_PREP), .THRESH(`PREP_MIN), .MARK(`MAP_AFTER)) u_prep (
		.clk(CORE_CLK_IN), .srst(SRST_IN), .ce(CE_IN), .byte_in(RX_BYTE_IN),
		.valid_in(RX_BYTE_VALID_IN), .hit_out(hit_prep), .mark_out(mark_prep));
	byte_run_counter #(.PATTERN(`PAT_ACT), .THRESH(`ACT_MIN), .MARK(`ACT_MIN)) u_act (
		.clk(CORE_CLK_IN), .srst(SRST_IN), .ce(CE_IN), .byte_in(RX_BYTE_IN),
		.valid_in(RX_BYTE_VALID_IN), .hit_out(hit_act), .mark_out());

	// Byte matches used to abandon a stage when a foreign byte breaks the sequence.
	assign m_sel_cur = (target_q == `TGT_DP) ? (RX_BYTE_IN[6:0] == `PAT_SEL_DP) :
		(target_q == `TGT_SVC) ? (RX_BYTE_IN[6:0] == `PAT_SEL_SVC) :
		(RX_BYTE_IN[6:0] == `PAT_SEL_NI);
	assign m_prep = (RX_BYTE_IN[6:0] == `PAT_PREP);
	assign m_act = (RX_BYTE_IN[6:0] == `PAT_ACT);

	// Protected mode begins by hunting the clearing run, otherwise the select run.
	assign start_state = eff[`OPT_PROTECTED] ? ST_HUNT_CLEAR : ST_HUNT_SEL; // [RULE_07] [RULE_23]
	assign timeout_hit = eff[`OPT_TIMEOUT] && ({24'h000000, timer_q} >= TIMEOUT_CYC - 64'd1);

	// Loopback sequence detector; a foreign byte in the prepare or activate stage restarts the hunt.
	always @(posedge CORE_CLK_IN) begin
		if (SRST_IN) begin
			state_q <= ST_HUNT_CLEAR;
			target_q <= `TGT_NONE;
			LOOPBACK_OUT <= 1'b0;
			MAP_SEND_OUT <= 1'b0;
			MAP_BYTE_OUT <= 8'h00;
		end else if (CE_IN) begin
			MAP_BYTE_OUT <= MAP_CODE;
			if (!eff[`OPT_LATCHING]) begin
				state_q <= start_state; // [RULE_14]
				target_q <= `TGT_NONE;
				LOOPBACK_OUT <= 1'b0;
				MAP_SEND_OUT <= 1'b0;
			end else if (hit_clear) begin
				state_q <= ST_HUNT_SEL; // [RULE_08]
				target_q <= `TGT_NONE;
				LOOPBACK_OUT <= 1'b0;
				MAP_SEND_OUT <= 1'b0;
			end else begin
				case (state_q)
				ST_HUNT_CLEAR: begin
					if (!eff[`OPT_PROTECTED])
						state_q <= ST_HUNT_SEL; // [RULE_23]
				end
				ST_HUNT_SEL: begin
					if (hit_dp) begin
						target_q <= `TGT_DP; // [RULE_09]
						state_q <= ST_PREP;
					end else if (hit_svc) begin
						target_q <= `TGT_SVC; // [RULE_09]
						state_q <= ST_PREP;
					end else if (hit_ni) begin
						target_q <= `TGT_NI; // [RULE_09]
						state_q <= ST_PREP;
					end
				end
				ST_PREP: begin
					if (mark_prep && target_q == `TGT_DP)
						MAP_SEND_OUT <= 1'b1; // [RULE_11]
					if (hit_prep) begin
						state_q <= ST_ACT; // [RULE_10]
					end else if (RX_BYTE_VALID_IN && !m_prep && !m_sel_cur) begin
						state_q <= start_state; // [RULE_13]
						target_q <= `TGT_NONE;
						MAP_SEND_OUT <= 1'b0;
					end
				end
				ST_ACT: begin
					if (hit_act) begin
						MAP_SEND_OUT <= 1'b0;
						if (target_q == `TGT_DP) begin
							LOOPBACK_OUT <= 1'b1; // [RULE_12]
							state_q <= ST_LOOPED;
						end else begin
							state_q <= start_state;
						end
					end else if (RX_BYTE_VALID_IN && !m_act && !m_prep) begin
						state_q <= start_state; // [RULE_13]
						target_q <= `TGT_NONE;
						MAP_SEND_OUT <= 1'b0;
					end
				end
				ST_LOOPED: begin
					if (timeout_hit) begin
						LOOPBACK_OUT <= 1'b0; // [RULE_15]
						state_q <= start_state;
						target_q <= `TGT_NONE;
					end
				end
				default: begin
					state_q <= start_state;
					target_q <= `TGT_NONE;
				end
				endcase
			end
		end
	end

	// Timeout timer runs only while looped with the timeout option on.
	always @(posedge CORE_CLK_IN) begin
		if (SRST_IN)
			timer_q <= 40'h0000000000;
		else if (CE_IN) begin
			if (state_q == ST_LOOPED && eff[`OPT_TIMEOUT] && !timeout_hit)
				timer_q <= timer_q + 40'h0000000001; // [RULE_15]
			else
				timer_q <= 40'h0000000000;
		end
	end

	// Options are resent after sync is gained and after any change while in sync.
	assign ovh_set = loop_sync && (!sync_prev_q || eff != eff_prev_q); // [RULE_20]

	// Overhead slots carry the option byte when pending, else a status byte.
	always @(posedge CORE_CLK_IN) begin
		if (SRST_IN) begin
			sync_prev_q <= 1'b0;
			eff_prev_q <= 7'h00;
			ovh_pend_q <= 1'b0;
			OVH_DATA_OUT <= 8'h00;
			OVH_VALID_OUT <= 1'b0;
		end else if (CE_IN) begin
			sync_prev_q <= loop_sync;
			eff_prev_q <= eff;
			OVH_VALID_OUT <= OVH_SLOT_IN && loop_sync; // [RULE_02]
			// A new option change wins over the send that clears the pending flag.
			ovh_pend_q <= ovh_set | (ovh_pend_q & ~OVH_SLOT_IN & loop_sync);
			if (OVH_SLOT_IN && loop_sync) begin
				if (ovh_pend_q)
					OVH_DATA_OUT <= {1'b1, eff}; // [RULE_20]
				else
					OVH_DATA_OUT <= {2'h0, LOOPBACK_OUT, MISMATCH_OUT, target_q, 2'h0}; // [RULE_02]
			end
		end
	end

	// Word-aligned decode of the low address bits; other offsets read as zero.
	assign addr_ok = HSEL_IN && HTRANS_IN[1] && HREADY_IN;

	always @* begin
		case (HADDR_IN[5:0])
		`REG_CTRL: rd_mux = {24'h000000, ctrl_q};
		`REG_STATUS: rd_mux = {18'h00000, loop_sync, MAP_SEND_OUT, MISMATCH_OUT,
			LOOPBACK_OUT, target_q, 1'b0, state_q, chan_n};
		`REG_SLOTS: rd_mux = {8'h00, SLOT_MASK_OUT};
		`REG_SWITCH: rd_mux = {16'h0000, 3'h0, card_slot, 1'b0, sw_opts};
		default: rd_mux = 32'h00000000;
		endcase
	end

	// Zero-wait slave: reads load in the address phase, writes land in the data phase.
	always @(posedge CORE_CLK_IN) begin
		if (SRST_IN) begin
			HRDATA_OUT <= 32'h00000000;
			HREADYOUT_OUT <= 1'b0;
			HRESP_OUT <= 1'b0;
			wr_pend_q <= 1'b0;
			wr_addr_q <= 6'h00;
			ctrl_q <= `CTRL_RESET;
		end else if (CE_IN) begin
			HREADYOUT_OUT <= 1'b1;
			HRESP_OUT <= 1'b0;
			wr_pend_q <= addr_ok && HWRITE_IN;
			wr_addr_q <= HADDR_IN[5:0];
			if (addr_ok && !HWRITE_IN)
				HRDATA_OUT <= (HADDR_IN[31:6] == 26'h0000000) ? rd_mux : 32'h00000000;
			if (wr_pend_q && wr_addr_q == `REG_CTRL)
				ctrl_q <= HWDATA_IN[7:0]; // [RULE_19]
		end
	end

endmodule

/* File: verification/bank_side_model.sv */
// Channel bank and remote unit model: byte stream, loop sync and overhead slots.
`timescale 1ns/1ps
module bank_side_model (
	// Clock.
	input wire clk_in,
	// Stream, slot strobe and sync toward the block.
	output logic [7:0] rx_byte_out = 8'h00,
	output logic rx_valid_out = 1'b0,
	output logic ovh_slot_out = 1'b0,
	output logic sync_out = 1'b0
);
	// Sends a code n times back to back with a random top bit; valid stays up.
	task send(input logic [6:0] code, input int n);
		logic top;
		repeat (n) begin
			top = 1'($urandom);
			rx_byte_out <= {top, code};
			rx_valid_out <= 1'b1;
			@(posedge clk_in);
		end
	endtask
	// Ends a burst; the byte lines flip so a stale code is never seen again.
	task idle();
		rx_valid_out <= 1'b0;
		rx_byte_out <= ~rx_byte_out;
		@(posedge clk_in);
	endtask
	// One overhead slot strobe, then a quiet cycle.
	task slot();
		ovh_slot_out <= 1'b1;
		@(posedge clk_in);
		ovh_slot_out <= 1'b0;
		@(posedge clk_in);
	endtask
	// Loop synchronisation level from the line side.
	task link(input logic b);
		sync_out <= b;
		@(posedge clk_in);
	endtask
endmodule

/* File: verification/loopback_ctrl_assertions.sv */
// Port-level checks for the loopback controller.
`timescale 1ns/1ps
`include "loopback_ctrl_defs.vh"
module loopback_ctrl_checker #(
	parameter [7:0] MAP_CODE = 8'h00
) (
	input wire CORE_CLK_IN,
	input wire SRST_IN,
	input wire HREADYOUT_OUT,
	input wire [4:0] CARD_SLOT_IN,
	input wire [7:0] RX_BYTE_IN,
	input wire RX_BYTE_VALID_IN,
	input wire OVH_SLOT_IN,
	input wire LINE_2B1Q_OUT,
	input wire [23:0] SLOT_MASK_OUT,
	input wire [10:0] RATE_KBPS_OUT,
	input wire LOOPBACK_OUT,
	input wire MAP_SEND_OUT,
	input wire [7:0] MAP_BYTE_OUT,
	input wire OVH_VALID_OUT
);
	// All checks share the core clock and stay quiet during reset.
	default clocking cb @(posedge CORE_CLK_IN);
	endclocking
	default disable iff (SRST_IN);
	chk_bus_zero_wait: assert property (!$past(SRST_IN) |-> HREADYOUT_OUT)
		else $error("bus not ready after reset");
	chk_loop_code: assert property (!$past(SRST_IN) |-> LINE_2B1Q_OUT)
		else $error("loop code flag low");
	chk_rate_mask: assert property ($stable(SLOT_MASK_OUT) [*2] |->
		RATE_KBPS_OUT == 11'($countones(SLOT_MASK_OUT) * 64)) else $error("rate off mask");
	chk_slot_max: assert property ($countones(SLOT_MASK_OUT) <= 12)
		else $error("too many slots");
	chk_slot_no_wrap: assert property ($stable(CARD_SLOT_IN) [*5] |->
		(SLOT_MASK_OUT & ((24'h1 << CARD_SLOT_IN) - 24'h1)) == 24'h0) else $error("slot wrap");
	chk_map_start: assert property ($rose(MAP_SEND_OUT) |-> $past(RX_BYTE_VALID_IN, 2) &&
		$past(RX_BYTE_IN[6:0], 2) == `PAT_PREP) else $error("map start without prepare");
	chk_map_code: assert property (MAP_SEND_OUT |-> MAP_BYTE_OUT == MAP_CODE)
		else $error("map code wrong");
	chk_loop_on_act: assert property ($rose(LOOPBACK_OUT) |-> !MAP_SEND_OUT &&
		$past(RX_BYTE_VALID_IN, 2) && $past(RX_BYTE_IN[6:0], 2) == `PAT_ACT) else $error("bad latch");
	chk_ovh_on_slot: assert property (OVH_VALID_OUT |-> $past(OVH_SLOT_IN) ##1 !OVH_VALID_OUT)
		else $error("overhead byte without slot");
endmodule
bind fractional_dataport_loopback_ctrl loopback_ctrl_checker #(.MAP_CODE(MAP_CODE)) checks (
	.CORE_CLK_IN(CORE_CLK_IN), .SRST_IN(SRST_IN), .HREADYOUT_OUT(HREADYOUT_OUT),
	.CARD_SLOT_IN(CARD_SLOT_IN), .RX_BYTE_IN(RX_BYTE_IN), .RX_BYTE_VALID_IN(RX_BYTE_VALID_IN),
	.OVH_SLOT_IN(OVH_SLOT_IN), .LINE_2B1Q_OUT(LINE_2B1Q_OUT), .SLOT_MASK_OUT(SLOT_MASK_OUT),
	.RATE_KBPS_OUT(RATE_KBPS_OUT), .LOOPBACK_OUT(LOOPBACK_OUT), .MAP_SEND_OUT(MAP_SEND_OUT),
	.MAP_BYTE_OUT(MAP_BYTE_OUT), .OVH_VALID_OUT(OVH_VALID_OUT));

/* File: verification/fractional_dataport_loopback_ctrl_bench.sv */
// Self-checking bench for the loopback controller.
`timescale 1ns/1ps
`include "loopback_ctrl_defs.vh"
module fractional_dataport_loopback_ctrl_bench;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [6:0] sw = 7'h00;
	logic [3:0] rot = 4'h2;
	logic [4:0] card = 5'h00;
	logic smp = 1'b0;
	logic rd_dp = 1'b0;
	logic [31:0] q[$];
	int error_cnt = 0;
	int cmp_count = 0;
	int cyc = 0;
	wire [7:0] rxb, ovhd;
	wire rxv, slot, sync, hready, hresp, b8zs, esf, four, loop, mapsend, ovhv, mism;
	wire [31:0] hrdata;
	wire [23:0] mask;
	always #2 clk = ~clk;
	bank_side_model far (.clk_in(clk), .rx_byte_out(rxb), .rx_valid_out(rxv),
		.ovh_slot_out(slot), .sync_out(sync));
	fractional_dataport_loopback_ctrl #(.TIMEOUT_CYC(64'd200), .MAP_CODE(8'h6C)) dut (
		.CORE_CLK_IN(clk), .SRST_IN(srst), .CE_IN(1'b1), .HSEL_IN(hsel), .HADDR_IN(haddr),
		.HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata),
		.HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
		.LINE_CODE_SWITCH_IN(sw[0]), .FRAMING_SWITCH_IN(sw[1]), .SLOT_PATTERN_SWITCH_IN(sw[2]),
		.LATCHING_LOOP_SWITCH_IN(sw[3]), .LOOP_TIMEOUT_SWITCH_IN(sw[4]),
		.BANK_TYPE_SWITCH_IN(sw[5]), .PROTECTED_LOOP_SWITCH_IN(sw[6]), .ROTARY_IN(rot),
		.CARD_SLOT_IN(card), .LOOP_SYNC_IN(sync), .RX_BYTE_IN(rxb), .RX_BYTE_VALID_IN(rxv),
		.OVH_SLOT_IN(slot), .B8ZS_OUT(b8zs), .ESF_OUT(esf), .FOUR_STATE_SIG_OUT(four),
		.LINE_2B1Q_OUT(), .SLOT_MASK_OUT(mask), .RATE_KBPS_OUT(), .LOOPBACK_OUT(loop),
		.MAP_SEND_OUT(mapsend), .MAP_BYTE_OUT(), .OVH_DATA_OUT(ovhd), .OVH_VALID_OUT(ovhv),
		.MISMATCH_OUT(mism));
	task check(input logic [31:0] seen, input logic [31:0] want);
		cmp_count++;
		if (seen !== want) begin
			error_cnt++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask
	task report_and_stop();
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// Results are matched in arrival order against the notes left by the driver.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (rd_dp && hready) begin
			check(hrdata, q.pop_front());
			check({31'h0, hresp}, 32'h0);
		end
		if (smp)
			check({26'h0, loop, mapsend, mism, four, esf, b8zs}, q.pop_front());
		if (ovhv)
			check({24'h0, ovhd}, q.pop_front());
		rd_dp <= hsel && htrans[1] && !hwrite && hready;
		if (cyc == 20000) begin
			error_cnt++;
			report_and_stop();
		end
	end
	// One single transfer; every phase is held until ready is seen.
	task bus(input logic [31:0] a, input logic w, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= w ? d : 32'h0;
		do @(posedge clk); while (hready !== 1'b1);
	endtask
	task rd(input logic [31:0] a, input logic [31:0] want);
		q.push_back(want);
		bus(a, 1'b0, 32'h0);
	endtask
	task pins(input logic [5:0] want);
		q.push_back({26'h0, want});
		smp <= 1'b1;
		@(posedge clk);
		smp <= 1'b0;
		@(posedge clk);
	endtask
	// Switches and craft options are set alike, so the mismatch flag settles low.
	task opts(input logic [6:0] o);
		sw <= o;
		bus(`REG_CTRL, 1'b1, {25'h0, o});
		repeat (6) @(posedge clk);
	endtask
	task latch_seq();
		far.send(`PAT_SEL_DP, 35);
		far.send(`PAT_PREP, 100);
		far.send(`PAT_ACT, 35);
		far.idle();
		repeat (2) @(posedge clk);
	endtask
	function automatic logic [23:0] slots(input int c, input int r, input logic contig);
		logic [23:0] m;
		int n;
		m = 24'h0;
		n = r < 2 ? 2 : r > 12 ? 12 : r;
		for (int i = 0; i < n; i++)
			if (c + (contig ? i : 2 * i) < 24)
				m[c + (contig ? i : 2 * i)] = 1'b1;
		return m;
	endfunction
	initial begin
		logic [6:0] v;
		logic [6:0] code;
		logic dp;
		void'($urandom(32'hEA10007A));
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		repeat (2) @(posedge clk);
		rd(`REG_CTRL, 32'h0);
		bus(`REG_CTRL, 1'b1, 32'h5A);
		rd(`REG_CTRL, 32'h5A);
		rd(32'h10, 32'h0);
		bus(`REG_CTRL, 1'b1, 32'h0);
		// Random switch sets, then the craft register overrides with the inverse.
		repeat (4) begin
			v = 7'($urandom);
			sw <= v;
			repeat (6) @(posedge clk);
			pins({2'b00, v != 7'h0, v[5], v[1], v[0]});
			rd(`REG_SWITCH, {19'h0, card, 1'b0, v});
			bus(`REG_CTRL, 1'b1, {24'h0, 1'b1, ~v});
			repeat (2) @(posedge clk);
			pins({3'b001, ~v[5], ~v[1], ~v[0]});
			bus(`REG_CTRL, 1'b1, {24'h0, 1'b0, v});
			repeat (2) @(posedge clk);
			pins({3'b000, v[5], v[1], v[0]});
		end
		// Slot maps; the first case sits near the bank's end and must not wrap.
		for (int k = 0; k < 6; k++) begin
			card <= k == 0 ? 5'h16 : 5'($urandom_range(23));
			rot <= k == 0 ? 4'h4 : 4'($urandom);
			sw[2] <= k[0];
			repeat (6) @(posedge clk);
			rd(`REG_SLOTS, {8'h0, slots(card, rot, sw[2])});
			pins({2'b00, sw != v, sw[5], sw[1], sw[0]});
		end
		// Protected mode without a clearing run must not latch.
		// Latching goes off first so the detector restarts in the protected start state.
		opts(7'h40);
		opts(7'h48);
		latch_seq();
		pins(6'h00);
		// Each target; only the dataport target returns the map code and loops.
		for (int t = 0; t < 3; t++) begin
			code = t == 0 ? `PAT_SEL_SVC : t == 1 ? `PAT_SEL_NI : `PAT_SEL_DP;
			dp = t == 2;
			far.send(`PAT_CLEAR, 35);
			far.send(code, 35);
			far.send(`PAT_PREP, 29);
			far.idle();
			pins(6'h00);
			far.send(`PAT_PREP, 1);
			far.idle();
			pins({1'b0, dp, 4'h0});
			far.send(`PAT_PREP, 70);
			far.send(`PAT_ACT, 34);
			far.idle();
			pins({1'b0, dp, 4'h0});
			far.send(`PAT_ACT, 1);
			far.idle();
			repeat (2) @(posedge clk);
			pins({dp, 5'h00});
		end
		repeat (250) @(posedge clk);
		pins(6'h20);
		far.send(`PAT_CLEAR, 34);
		far.send(7'h00, 1);
		far.send(`PAT_CLEAR, 1);
		far.idle();
		repeat (2) @(posedge clk);
		pins(6'h20);
		far.send(`PAT_CLEAR, 35);
		far.idle();
		repeat (2) @(posedge clk);
		pins(6'h00);
		// Unprotected mode latches without clearing; the timeout then releases it.
		opts(7'h18);
		latch_seq();
		pins(6'h20);
		repeat (210) @(posedge clk);
		pins(6'h00);
		opts(7'h08);
		latch_seq();
		pins(6'h20);
		opts(7'h00);
		pins(6'h00);
		latch_seq();
		pins(6'h00);
		// No overhead byte before sync; after sync the option byte goes first.
		opts(7'h55);
		far.slot();
		far.link(1'b1);
		repeat (6) @(posedge clk);
		q.push_back(32'hD5);
		far.slot();
		// With nothing pending the next slot carries the idle status byte.
		q.push_back(32'h00);
		far.slot();
		rd(`REG_STATUS, 32'h2000 | (rot < 2 ? 2 : rot > 12 ? 12 : rot));
		repeat (4) @(posedge clk);
		report_and_stop();
	end
endmodule
